/* File: osw_pkg.sv */
package osw_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_KICK     = 8'h04;
	localparam logic [7:0] OFF_PERIOD   = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_COUNT    = 8'h10;
	localparam logic [7:0] OFF_EVT_STAT = 8'h14;
	localparam logic [7:0] OFF_EVT_CLR  = 8'h18;
	localparam logic [7:0] OFF_EVT_EN   = 8'h1c;
	localparam logic [7:0] OFF_SAFE_EN  = 8'h20;
	localparam logic [7:0] OFF_DEV_RST  = 8'h24;
	localparam logic [7:0] OFF_SAFE_VAL = 8'h40;

	// field positions
	localparam int unsigned CTRL_ARM_BIT     = 0;
	localparam int unsigned CTRL_NETLOSS_BIT = 1;
	localparam int unsigned KICK_BIT         = 0;
	localparam int unsigned DEV_RST_BIT      = 0;
	localparam int unsigned ST_ARMED_BIT     = 0;
	localparam int unsigned ST_EXPIRED_BIT   = 1;
	localparam int unsigned ST_LINK_BIT      = 2;
	localparam int unsigned ST_BUSY_BIT      = 3;
	localparam int unsigned EVT_TIMEOUT_BIT  = 0;
	localparam int unsigned EVT_NETLOSS_BIT  = 1;
	localparam int unsigned EVT_REFUSED_BIT  = 2;
	localparam int unsigned EVT_W            = 3;

	// reset values
	localparam logic [31:0]      PERIOD_RST  = 32'hffff_ffff;
	localparam logic [EVT_W-1:0] EVT_RST     = 3'h0;
	localparam logic [31:0]      RDATA_RST   = 32'h0000_0000;

	// timing: counter ticks of 25 ns, clock period 50 ns
	localparam int unsigned TICK_NS       = 25;
	localparam int unsigned CLK_NS        = 50;
	localparam int unsigned TICKS_PER_CLK = CLK_NS / TICK_NS;
	localparam int unsigned CNT_W         = 32;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_EXPIRED = 2'b10
	} osw_state_e;

endpackage : osw_pkg

/* File: osw_tmr_if.sv */
interface osw_tmr_if;
	logic        load;
	logic        run;
	logic [31:0] period;
	logic [31:0] remain;
	logic        elapsed;

	modport ctl (output load, output run, output period, input remain, input elapsed);
	modport tmr (input load, input run, input period, output remain, output elapsed);
endinterface : osw_tmr_if

/* File: osw_timer.sv */
module osw_timer (
	input  wire logic clk,
	input  wire logic sys_rst,
	osw_tmr_if.tmr    tif
);

	localparam logic [31:0] STEP = 32'(osw_pkg::TICKS_PER_CLK);

	logic [31:0] remain_r;

	// reload wins over counting; stops at zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			remain_r <= osw_pkg::PERIOD_RST;
		end else if (tif.load) begin
			remain_r <= tif.period;
		end else if (tif.run) begin
			if (remain_r > STEP) begin
				remain_r <= remain_r - STEP;
			end else begin
				remain_r <= 32'h0000_0000;
			end
		end
	end

	assign tif.remain  = remain_r;
	assign tif.elapsed = tif.run && (remain_r == 32'h0000_0000);

endmodule : osw_timer

/* File: osw_watchdog.sv */
// Overview of operation
// - missed kick while armed expires to safe states
// - safe states held until device reset
// - expired device refuses writes except device reset, event clear and event enable
// - optional network loss expiry, independent of counter
// - 32-bit timeout counter in 25 ns ticks
// - per-channel safe-state enable; others left untouched
// - device reset restores power-up outputs, clears expiry
module osw_watchdog #(
	parameter int unsigned      NUM_CH   = 4,
	parameter int unsigned      DATA_W   = 16,
	parameter logic [DATA_W-1:0] PWRUP_VAL = '0
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     net_link,
	input  wire logic                     ops_busy,
	input  wire logic [NUM_CH*DATA_W-1:0] ch_in,
	output logic      [NUM_CH*DATA_W-1:0] ch_out,
	output logic                          op_allow,
	output logic                          dev_reset_pulse,
	output logic                          expired_o,
	output logic                          irq
);

	osw_pkg::osw_state_e state_r;

	logic [31:0]             period_r;
	logic                    netloss_en_r;
	logic [NUM_CH-1:0]       safe_en_r;
	logic [DATA_W-1:0]       safe_val_r [NUM_CH];
	logic [osw_pkg::EVT_W-1:0] evt_r;
	logic [osw_pkg::EVT_W-1:0] evt_en_r;
	logic [31:0]             prdata_r;
	logic                    dev_rst_r;
	logic [NUM_CH*DATA_W-1:0] ch_out_r;

	logic                    access;
	logic                    wr;
	logic                    mapped;
	logic                    refuse;
	logic                    is_safe_val;
	logic [5:0]              word_idx;
	logic [5:0]              sv_idx;
	logic                    kick;
	logic                    arm_req;
	logic                    dev_rst_req;
	logic                    exp_timeout;
	logic                    exp_netloss;
	logic [osw_pkg::EVT_W-1:0] evt_set;
	logic [osw_pkg::EVT_W-1:0] evt_clr;
	logic [31:0]             rd_mux;
	logic                    wr_ok;
	logic                    wr_ctrl;
	logic                    wr_kick;
	logic                    wr_period;
	logic                    wr_safe_en;
	logic                    wr_evt_en;
	logic                    wr_evt_clr;
	logic                    wr_safe_val;
	logic                    rd_setup;
	logic                    st_idle;
	logic                    st_armed;
	logic                    st_expired;
	wire  [NUM_CH-1:0]       sv_sel;
	wire  [NUM_CH-1:0]       go_safe;

	osw_tmr_if tif ();

	osw_timer u_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tif     (tif)
	);

	// ---------------- bus decode ----------------
	assign access   = psel && penable;
	assign wr       = access && pwrite;
	assign rd_setup = psel && !penable;
	assign word_idx = paddr[7:2];
	assign sv_idx   = word_idx - osw_pkg::OFF_SAFE_VAL[7:2];
	assign is_safe_val = (paddr >= osw_pkg::OFF_SAFE_VAL)
		&& (32'(sv_idx) < NUM_CH) && (paddr[1:0] == 2'b00);

	// unmapped words answer with an error
	always_comb begin
		unique case (paddr)
			osw_pkg::OFF_CTRL, osw_pkg::OFF_KICK, osw_pkg::OFF_PERIOD,
			osw_pkg::OFF_STATUS, osw_pkg::OFF_COUNT, osw_pkg::OFF_EVT_STAT,
			osw_pkg::OFF_EVT_CLR, osw_pkg::OFF_EVT_EN, osw_pkg::OFF_SAFE_EN,
			osw_pkg::OFF_DEV_RST: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = is_safe_val;
			end
		endcase
	end

	// writes refused while expired, except recovery and interrupt upkeep
	always_comb begin
		refuse = 1'b0;
		if (wr && mapped) begin
			if (state_r == osw_pkg::ST_EXPIRED) begin
				refuse = (paddr != osw_pkg::OFF_DEV_RST)
					&& (paddr != osw_pkg::OFF_EVT_CLR)
					&& (paddr != osw_pkg::OFF_EVT_EN);
			end else if (paddr == osw_pkg::OFF_CTRL) begin
				// control word locked once armed; arming needs a quiet device
				refuse = (state_r == osw_pkg::ST_ARMED)
					|| (pwdata[osw_pkg::CTRL_ARM_BIT] && ops_busy);
			end
		end
	end

	assign pready  = 1'b1;
	assign pslverr = access && (!mapped || refuse);

	// write strobes; a refused write only sets the refused event
	assign wr_ok       = wr && !refuse;
	assign wr_ctrl     = wr_ok && (paddr == osw_pkg::OFF_CTRL);
	assign wr_kick     = wr_ok && (paddr == osw_pkg::OFF_KICK);
	assign wr_period   = wr_ok && (paddr == osw_pkg::OFF_PERIOD);
	assign wr_safe_en  = wr_ok && (paddr == osw_pkg::OFF_SAFE_EN);
	assign wr_safe_val = wr_ok && is_safe_val;
	assign wr_evt_en   = wr && (paddr == osw_pkg::OFF_EVT_EN);
	assign wr_evt_clr  = wr && (paddr == osw_pkg::OFF_EVT_CLR);

	// control requests
	assign kick        = wr_kick && pwdata[osw_pkg::KICK_BIT] && st_armed;
	assign arm_req     = wr_ctrl && pwdata[osw_pkg::CTRL_ARM_BIT] && st_idle;
	assign dev_rst_req = wr && (paddr == osw_pkg::OFF_DEV_RST)
		&& pwdata[osw_pkg::DEV_RST_BIT];

	// state decode
	assign st_idle    = (state_r == osw_pkg::ST_IDLE);
	assign st_armed   = (state_r == osw_pkg::ST_ARMED);
	assign st_expired = (state_r == osw_pkg::ST_EXPIRED);

	// ---------------- expiry causes ----------------
	assign exp_timeout = (state_r == osw_pkg::ST_ARMED) && tif.elapsed && !kick;
	assign exp_netloss = (state_r == osw_pkg::ST_ARMED) && netloss_en_r
		&& !net_link;

	// ---------------- timer control ----------------
	assign tif.period = period_r;
	assign tif.load   = arm_req || kick;
	assign tif.run    = (state_r == osw_pkg::ST_ARMED);

	// ---------------- state machine ----------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= osw_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				osw_pkg::ST_IDLE: begin
					if (arm_req) begin
						state_r <= osw_pkg::ST_ARMED;
					end
				end
				osw_pkg::ST_ARMED: begin
					if (dev_rst_req) begin
						state_r <= osw_pkg::ST_IDLE;
					end else if (exp_timeout || exp_netloss) begin
						state_r <= osw_pkg::ST_EXPIRED;
					end
				end
				osw_pkg::ST_EXPIRED: begin
					// kicks have no way out, only a device reset
					if (dev_rst_req) begin
						state_r <= osw_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= osw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ---------------- configuration registers ----------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			period_r <= osw_pkg::PERIOD_RST;
		end else if (wr_period) begin
			period_r <= pwdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || dev_rst_req) begin
			netloss_en_r <= 1'b0;
		end else if (wr_ctrl) begin
			netloss_en_r <= pwdata[osw_pkg::CTRL_NETLOSS_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || dev_rst_req) begin
			safe_en_r <= '0;
		end else if (wr_safe_en) begin
			safe_en_r <= pwdata[NUM_CH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			evt_en_r <= osw_pkg::EVT_RST;
		end else if (wr_evt_en) begin
			evt_en_r <= pwdata[osw_pkg::EVT_W-1:0];
		end
	end

	// ---------------- sticky events, set beats clear ----------------
	always_comb begin
		evt_set = '0;
		evt_set[osw_pkg::EVT_TIMEOUT_BIT] = exp_timeout && !dev_rst_req;
		evt_set[osw_pkg::EVT_NETLOSS_BIT] = exp_netloss && !dev_rst_req;
		evt_set[osw_pkg::EVT_REFUSED_BIT] = refuse;
	end

	assign evt_clr = wr_evt_clr
		? pwdata[osw_pkg::EVT_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			evt_r <= osw_pkg::EVT_RST;
		end else begin
			evt_r <= (evt_r & ~evt_clr) | evt_set;
		end
	end

	assign irq = |(evt_r & evt_en_r);

	// ---------------- per-channel outputs ----------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			// word select and safe-state switch of this channel
			assign sv_sel[gi]  = wr_safe_val && (32'(sv_idx) == gi);
			assign go_safe[gi] = st_expired && safe_en_r[gi];

			always_ff @(posedge clk) begin
				if (sys_rst || dev_rst_req) begin
					safe_val_r[gi] <= '0;
				end else if (sv_sel[gi]) begin
					safe_val_r[gi] <= pwdata[DATA_W-1:0];
				end
			end

			always_ff @(posedge clk) begin
				if (sys_rst || dev_rst_req) begin
					ch_out_r[gi*DATA_W +: DATA_W] <= PWRUP_VAL;
				end else if (go_safe[gi]) begin
					ch_out_r[gi*DATA_W +: DATA_W] <= safe_val_r[gi];
				end else begin
					ch_out_r[gi*DATA_W +: DATA_W] <= ch_in[gi*DATA_W +: DATA_W];
				end
			end
		end
	endgenerate

	assign ch_out = ch_out_r;

	// ---------------- device reset pulse ----------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dev_rst_r <= 1'b0;
		end else begin
			dev_rst_r <= dev_rst_req;
		end
	end

	assign dev_reset_pulse = dev_rst_r;
	assign expired_o       = st_expired;
	assign op_allow        = !st_expired;

	// ---------------- read data, captured in setup phase ----------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_safe_val) begin
			rd_mux[DATA_W-1:0] = safe_val_r[sv_idx[$clog2(NUM_CH)-1:0]];
		end else begin
			unique case (paddr)
				osw_pkg::OFF_CTRL: begin
					rd_mux[osw_pkg::CTRL_ARM_BIT]     = (state_r == osw_pkg::ST_ARMED);
					rd_mux[osw_pkg::CTRL_NETLOSS_BIT] = netloss_en_r;
				end
				osw_pkg::OFF_PERIOD: begin
					rd_mux = period_r;
				end
				osw_pkg::OFF_STATUS: begin
					rd_mux[osw_pkg::ST_ARMED_BIT]   = (state_r == osw_pkg::ST_ARMED);
					rd_mux[osw_pkg::ST_EXPIRED_BIT] = (state_r == osw_pkg::ST_EXPIRED);
					rd_mux[osw_pkg::ST_LINK_BIT]    = net_link;
					rd_mux[osw_pkg::ST_BUSY_BIT]    = ops_busy;
				end
				osw_pkg::OFF_COUNT: begin
					rd_mux = tif.remain;
				end
				osw_pkg::OFF_EVT_STAT: begin
					rd_mux[osw_pkg::EVT_W-1:0] = evt_r;
				end
				osw_pkg::OFF_EVT_EN: begin
					rd_mux[osw_pkg::EVT_W-1:0] = evt_en_r;
				end
				osw_pkg::OFF_SAFE_EN: begin
					rd_mux[NUM_CH-1:0] = safe_en_r;
				end
				osw_pkg::OFF_KICK, osw_pkg::OFF_EVT_CLR, osw_pkg::OFF_DEV_RST: begin
					// write-only words read as zero
					rd_mux = 32'h0000_0000;
				end
				default: begin
					rd_mux = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_r <= osw_pkg::RDATA_RST;
		end else if (rd_setup) begin
			prdata_r <= rd_mux;
		end
	end

	assign prdata = prdata_r;

endmodule : osw_watchdog

/* File: osw_watchdog_assertions.sv */
module osw_chk #(
	parameter int unsigned       NUM_CH    = 4,
	parameter int unsigned       DATA_W    = 16,
	parameter logic [DATA_W-1:0] PWRUP_VAL = '0
) (
	input wire logic                     clk,
	input wire logic                     sys_rst,
	input wire logic [7:0]               paddr,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     net_link,
	input wire logic                     ops_busy,
	input wire logic [NUM_CH*DATA_W-1:0] ch_in,
	input wire logic [NUM_CH*DATA_W-1:0] ch_out,
	input wire logic                     op_allow,
	input wire logic                     dev_reset_pulse,
	input wire logic                     expired_o,
	input wire logic                     irq
);
	logic wr_acc;
	logic dev_wr;
	logic kick_wr;
	logic recov_wr;
	assign wr_acc = psel && penable && pwrite;
	assign dev_wr = wr_acc && paddr == osw_pkg::OFF_DEV_RST && pwdata[osw_pkg::DEV_RST_BIT];
	assign kick_wr = wr_acc && paddr == osw_pkg::OFF_KICK && pwdata[osw_pkg::KICK_BIT];
	assign recov_wr = paddr == osw_pkg::OFF_DEV_RST || paddr == osw_pkg::OFF_EVT_CLR
		|| paddr == osw_pkg::OFF_EVT_EN;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	exp_hold_a: assert property (expired_o && !dev_wr |=> expired_o)
		else $error("expiry left without reset");
	op_block_a: assert property (expired_o && wr_acc && !recov_wr |-> pslverr)
		else $error("operation accepted while expired");
	kick_refuse_a: assert property (expired_o && kick_wr |-> pslverr)
		else $error("kick accepted while expired");
	allow_back_a: assert property ($rose(op_allow) |-> $past(dev_wr))
		else $error("operations resumed without reset");
	rst_pulse_a: assert property (dev_wr |=> dev_reset_pulse)
		else $error("no reset pulse");
	rst_clear_a: assert property (dev_wr |=> !expired_o)
		else $error("expiry not cleared by reset");
	pwrup_out_a: assert property (dev_wr |=> ch_out == {NUM_CH{PWRUP_VAL}})
		else $error("outputs not at power-up value");
	kick_live_a: assert property (kick_wr && net_link && !expired_o |=> !expired_o)
		else $error("expired despite kick");
	cover property (kick_wr && !expired_o);
	cover property ($rose(expired_o));
	cover property (dev_wr && expired_o);
endmodule : osw_chk

bind osw_watchdog osw_chk #(.NUM_CH(NUM_CH), .DATA_W(DATA_W), .PWRUP_VAL(PWRUP_VAL))
	osw_chk_inst (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .net_link, .ops_busy, .ch_in, .ch_out, .op_allow,
	.dev_reset_pulse, .expired_o, .irq);

/* File: osw_host_model.sv */
module osw_host_model (
	input wire logic         clk,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic [31:0]  prdata,
	output logic     [7:0]   paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic     [31:0]  pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one apb transfer; caller enters just after a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic t);
		int n;
		n = 0;
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1 && n < 16) begin
			n++;
			@(posedge clk);
		end
		t = (n == 16);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// idle edge so the next setup never shares this time step
		@(posedge clk);
	endtask : xfer
endmodule : osw_host_model

/* File: testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, sys_rst, net_link, ops_busy, psel, penable, pwrite;
	logic        pready, pslverr, op_allow, dev_reset_pulse, expired_o, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [63:0] ch_in, ch_out;
	int          error_cnt = 0;
	int          total_checks = 0;
	osw_watchdog osw_watchdog_inst (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .net_link, .ops_busy, .ch_in, .ch_out,
		.op_allow, .dev_reset_pulse, .expired_o, .irq);
	osw_host_model osw_host_model_inst (.clk, .pready, .pslverr, .prdata, .paddr, .psel,
		.penable, .pwrite, .pwdata);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'h1) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic e, input logic [31:0] x);
		logic [31:0] q;
		logic        er;
		logic        t;
		osw_host_model_inst.xfer(a, w, d, q, er, t);
		if (t) begin
			error_cnt++;
			print_verdict();
		end
		chk(er === e, "bus response");
		if (!w) chk(q === x, "read data");
	endtask : xf
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'h0);
		xf(a, 1'h1, d, e, 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e = 1'h0);
		xf(a, 1'h0, 32'h0, e, x);
	endtask : rd
	task automatic wait_exp(input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (expired_o !== 1'h1 && n < hi);
		if (expired_o !== 1'h1) begin
			error_cnt++;
			print_verdict();
		end
		chk(n >= lo, "expiry too early");
		@(posedge clk);
	endtask : wait_exp
	task automatic s_reset_vals();
		rd(osw_pkg::OFF_PERIOD, 32'hffff_ffff);
		rd(osw_pkg::OFF_EVT_EN, 32'h0);
		rd(osw_pkg::OFF_SAFE_EN, 32'h0);
		rd(8'h30, 32'h0, 1'h1);
		wr(osw_pkg::OFF_KICK, 32'h1);
	endtask : s_reset_vals
	task automatic s_timeout();
		wr(osw_pkg::OFF_PERIOD, 32'h10);
		wr(osw_pkg::OFF_SAFE_EN, 32'h1);
		wr(osw_pkg::OFF_SAFE_VAL, 32'h5a5a);
		wr(osw_pkg::OFF_EVT_EN, 32'h7);
		wr(osw_pkg::OFF_CTRL, 32'h1);
		rd(osw_pkg::OFF_COUNT, 32'he);
		repeat (4) wr(osw_pkg::OFF_KICK, 32'h1);
		wait_exp(8, 11);
		@(negedge clk);
		chk(ch_out[15:0] === 16'h5a5a, "safe value");
		chk(ch_out[63:16] === ch_in[63:16], "unconfigured channel");
		chk(op_allow === 1'h0, "operations allowed");
		chk(irq === 1'h1, "irq not raised");
		@(posedge clk);
		rd(osw_pkg::OFF_EVT_STAT, 32'h1);
		rd(osw_pkg::OFF_STATUS, 32'h6);
		wr(osw_pkg::OFF_KICK, 32'h1, 1'h1);
		wr(osw_pkg::OFF_PERIOD, 32'h4, 1'h1);
		rd(osw_pkg::OFF_PERIOD, 32'h10);
		@(negedge clk);
		chk(ch_out[15:0] === 16'h5a5a, "safe value lost");
		@(posedge clk);
		wr(osw_pkg::OFF_DEV_RST, 32'h1);
		@(negedge clk);
		chk(expired_o === 1'h0 && op_allow === 1'h1, "still expired");
		chk(ch_out[15:0] === ch_in[15:0], "output not restored");
		@(posedge clk);
		rd(osw_pkg::OFF_SAFE_EN, 32'h0);
		wr(osw_pkg::OFF_EVT_CLR, 32'h7);
		rd(osw_pkg::OFF_EVT_STAT, 32'h0);
	endtask : s_timeout
	task automatic s_netloss();
		wr(osw_pkg::OFF_PERIOD, 32'hffff_ffff);
		rd(osw_pkg::OFF_PERIOD, 32'hffff_ffff);
		ops_busy <= 1'h1;
		wr(osw_pkg::OFF_CTRL, 32'h1, 1'h1);
		ops_busy <= 1'h0;
		wr(osw_pkg::OFF_CTRL, 32'h3);
		net_link <= 1'h0;
		wait_exp(1, 4);
		@(negedge clk);
		chk(irq === 1'h1, "irq not raised");
		@(posedge clk);
		rd(osw_pkg::OFF_EVT_STAT, 32'h6);
		wr(osw_pkg::OFF_EVT_EN, 32'h0);
		@(negedge clk);
		chk(irq === 1'h0, "irq not masked");
		@(posedge clk);
		net_link <= 1'h1;
		wr(osw_pkg::OFF_DEV_RST, 32'h1);
		wr(osw_pkg::OFF_EVT_CLR, 32'h7);
		rd(osw_pkg::OFF_EVT_STAT, 32'h0);
	endtask : s_netloss
	initial begin
		sys_rst = 1'h1;
		net_link = 1'h1;
		ops_busy = 1'h0;
		ch_in = 64'h1234_5678_9abc_def0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		s_reset_vals();
		s_timeout();
		s_netloss();
		print_verdict();
	end
endmodule : testbench
